// File: core/bals_pkg.sv
/*
 package of the byte alu datapath: register offsets, command field positions,
 reset values, operation codes, state codes and the apb request carrier.
 assumes a 32-bit apb bus with byte addresses.
*/
`default_nettype none
package bals_pkg;
    localparam int ADDR_W = 12;

    // register byte offsets
    localparam logic [11:0] CMD_OFS   = 12'h000;
    localparam logic [11:0] ACC_OFS   = 12'h004;
    localparam logic [11:0] FLAG_OFS  = 12'h008;
    localparam logic [11:0] PTR0_OFS  = 12'h00C;
    localparam logic [11:0] PTR1_OFS  = 12'h010;
    localparam logic [11:0] STAT_OFS  = 12'h014;
    localparam logic [2:0]  RF_PAGE   = 3'h1;

    // command field positions
    localparam int OP_POS    = 0;
    localparam int DEST_POS  = 3;
    localparam int PSEL_POS  = 4;
    localparam int LIT_POS   = 8;
    localparam int FADDR_POS = 16;

    // flag and status bit positions
    localparam int C_POS     = 0;
    localparam int DC_POS    = 1;
    localparam int Z_POS     = 2;
    localparam int BUSY_POS  = 0;
    localparam int RES_POS   = 8;

    // file addresses that reach memory through a pointer
    localparam logic [6:0] IND0_ADDR = 7'h00;
    localparam logic [6:0] IND1_ADDR = 7'h01;

    // reset values
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic [15:0] PTR_RST  = 16'h0000;

    typedef enum logic [2:0] {
        add_literal_to_pointer   = 3'h0,
        and_literal_accumulator  = 3'h1,
        add_literal_accumulator  = 3'h2,
        and_accumulator_register = 3'h3,
        add_accumulator_register = 3'h4,
        arith_shift_right        = 3'h5,
        add_with_carry_register  = 3'h6,
        op_none                  = 3'h7
    } bals_op_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_EXEC  = 2'h1,
        ST_EXTRA = 2'h2
    } bals_state_type;

    typedef struct packed {
        logic [6:0]  faddr;
        logic [7:0]  lit;
        logic        ptr_sel;
        logic        dest;
        bals_op_type op;
    } bals_cmd_type;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [31:0]       pwdata;
    } bals_apb_req_type;

    function automatic logic bals_reg_op(input bals_op_type op);
        return op == and_accumulator_register || op == add_accumulator_register ||
               op == arith_shift_right || op == add_with_carry_register;
    endfunction
endpackage
`default_nettype wire

// File: core/bals_alu.sv
/*
 byte alu datapath with its accumulator, flags, two pointers and a
 128-byte register file, all reached over apb; a command write runs one op.
 assumes an apb master on pclk that holds each request until pready.
*/
// Implementation choices: the placing of the registers and register access over APB.
//
// Contract
// (RQ1) add-literal-to-pointer adds a sign-extended 6-bit literal to pointer 0 or 1 and leaves the flags alone.
// (RQ2) the pointer sum wraps within sixteen bits.
// (RQ3) and-literal puts accumulator AND literal into the accumulator and changes only zero.
// (RQ4) add-literal puts accumulator plus literal into the accumulator and sets carry, nibble carry and zero.
// (RQ5) and-register ANDs the accumulator with the addressed register to the chosen place, changing only zero.
// (RQ6) destination bit 0 writes the accumulator and 1 writes the addressed register.
// (RQ7) add-register adds accumulator and register to the chosen place and sets carry, nibble carry and zero.
// (RQ8) the arithmetic shift moves bits 7:1 to 6:0 and bit 0 into carry.
// (RQ9) the shift keeps bit 7, changes only carry and zero, and goes to the chosen place.
// (RQ10) add-with-carry sums accumulator, register and carry to the chosen place and sets all three flags.
// (RQ11) an op on an indirect address whose pointer has its top bit set takes one extra cycle.
// (RQ12) carry is out of bit 7, nibble carry out of bit 3, and zero marks a zero result.
`timescale 1ns/1ps
`default_nettype none

module bals_alu #(
    parameter int ADDR_W = bals_pkg::ADDR_W
) (
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // apb slave
    input  wire bals_pkg::bals_apb_req_type apb_req,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr
);
    import bals_pkg::*;

    if (ADDR_W != 12) begin : g_chk
        $error("bals_alu serves only a 12-bit apb address");
    end

    typedef struct packed {
        bals_state_type  state;
        bals_cmd_type    cmd;
        logic [7:0]      acc;
        logic            c;
        logic            dc;
        logic            z;
        logic [15:0]     ptr0;
        logic [15:0]     ptr1;
        logic [7:0]      res;
        logic            rdy;
        logic            err;
        logic [31:0]     rdata;
        logic [127:0][7:0] rf;
    } bals_reg_type;

    bals_reg_type s;
    bals_reg_type next_s;

    logic [11:0]  a;
    logic         take;
    logic         mapped;
    logic         rf_hit;
    logic [6:0]   rf_idx;
    bals_cmd_type cmd_in;
    logic         needs_extra;
    logic [6:0]   fidx;
    logic [7:0]   fval;
    logic         lit_op;
    logic [7:0]   opnd;
    logic         cin;
    logic [8:0]   sum9;
    logic [4:0]   nib5;
    logic [7:0]   andv;
    logic [7:0]   asrv;
    logic [15:0]  sext;
    logic [15:0]  psum;
    logic [7:0]   res;
    logic         exec;

    assign a      = apb_req.paddr;
    assign rf_hit = a[11:9] == RF_PAGE;
    assign rf_idx = a[8:2];
    assign mapped = rf_hit || a == CMD_OFS || a == ACC_OFS || a == FLAG_OFS ||
                    a == PTR0_OFS || a == PTR1_OFS || a == STAT_OFS;
    assign take   = apb_req.psel && apb_req.penable && s.rdy;
    assign exec   = s.state == ST_EXEC;

    assign cmd_in.op      = bals_op_type'(apb_req.pwdata[OP_POS +: 3]);
    assign cmd_in.dest    = apb_req.pwdata[DEST_POS];
    assign cmd_in.ptr_sel = apb_req.pwdata[PSEL_POS];
    assign cmd_in.lit     = apb_req.pwdata[LIT_POS +: 8];
    assign cmd_in.faddr   = apb_req.pwdata[FADDR_POS +: 7];

    // stall one cycle when memory is reached through a high pointer
    assign needs_extra = bals_reg_op(cmd_in.op) &&               // [RQ11]
                         ((cmd_in.faddr == IND0_ADDR && s.ptr0[15]) ||
                          (cmd_in.faddr == IND1_ADDR && s.ptr1[15]));

    // indirect addresses resolve through the matching pointer
    assign fidx = s.cmd.faddr == IND0_ADDR ? s.ptr0[6:0] :
                  s.cmd.faddr == IND1_ADDR ? s.ptr1[6:0] : s.cmd.faddr;
    assign fval = s.rf[fidx];

    assign lit_op = s.cmd.op == and_literal_accumulator ||
                    s.cmd.op == add_literal_accumulator;
    assign opnd   = lit_op ? s.cmd.lit : fval;
    assign cin    = s.cmd.op == add_with_carry_register ? s.c : 1'b0;   // [RQ10]
    assign sum9   = {1'b0, s.acc} + {1'b0, opnd} + {8'h00, cin};        // [RQ12]
    assign nib5   = {1'b0, s.acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    assign andv   = s.acc & opnd;
    assign asrv   = {fval[7], fval[7:1]};                               // [RQ8] [RQ9]
    assign sext   = {{10{s.cmd.lit[5]}}, s.cmd.lit[5:0]};               // [RQ1]
    // sixteen-bit sum drops the carry out, so the pointer wraps
    assign psum   = (s.cmd.ptr_sel ? s.ptr1 : s.ptr0) + sext;           // [RQ2]

    always_comb begin
        unique case (s.cmd.op)
            and_literal_accumulator,
            and_accumulator_register: res = andv;
            arith_shift_right:        res = asrv;
            default:                  res = sum9[7:0];
        endcase
    end

    always_comb begin
        next_s = s;
        // bus handshake: ready after a selected request seen while idle, in setup or access
        next_s.rdy = apb_req.psel && s.state == ST_IDLE && !(apb_req.penable && s.rdy);
        // read data loads whenever ready is armed, also after waiting out a busy op
        if (apb_req.psel && s.state == ST_IDLE && !s.rdy) begin
            next_s.err   = !mapped;
            next_s.rdata = 32'h0000_0000;
            if (!apb_req.pwrite && rf_hit) begin
                next_s.rdata[7:0] = s.rf[rf_idx];
            end else if (!apb_req.pwrite) begin
                unique case (a)
                    CMD_OFS:  next_s.rdata[22:0] = {s.cmd.faddr, s.cmd.lit, 3'h0,
                                                    s.cmd.ptr_sel, s.cmd.dest, s.cmd.op};
                    ACC_OFS:  next_s.rdata[7:0]  = s.acc;
                    FLAG_OFS: next_s.rdata[2:0]  = {s.z, s.dc, s.c};
                    PTR0_OFS: next_s.rdata[15:0] = s.ptr0;
                    PTR1_OFS: next_s.rdata[15:0] = s.ptr1;
                    STAT_OFS: next_s.rdata[15:0] = {s.res, 7'h00, 1'b0};
                    default:  next_s.rdata       = 32'h0000_0000;
                endcase
            end
        end
        if (take && apb_req.pwrite) begin
            if (rf_hit) begin
                next_s.rf[rf_idx] = apb_req.pwdata[7:0];
            end else begin
                unique case (a)
                    CMD_OFS: begin
                        next_s.cmd   = cmd_in;
                        next_s.state = needs_extra ? ST_EXTRA : ST_EXEC;
                    end
                    ACC_OFS:  next_s.acc  = apb_req.pwdata[7:0];
                    FLAG_OFS: begin
                        next_s.c  = apb_req.pwdata[C_POS];
                        next_s.dc = apb_req.pwdata[DC_POS];
                        next_s.z  = apb_req.pwdata[Z_POS];
                    end
                    PTR0_OFS: next_s.ptr0 = apb_req.pwdata[15:0];
                    PTR1_OFS: next_s.ptr1 = apb_req.pwdata[15:0];
                    default:  next_s.acc  = s.acc;
                endcase
            end
        end
        unique case (s.state)
            ST_IDLE: begin
                next_s.state = next_s.state;
            end
            ST_EXTRA: begin
                next_s.state = ST_EXEC;                                 // [RQ11]
            end
            ST_EXEC: begin
                next_s.state = ST_IDLE;
                if (s.cmd.op == add_literal_to_pointer) begin
                    // pointer add leaves every flag as it was
                    if (s.cmd.ptr_sel) begin                            // [RQ1]
                        next_s.ptr1 = psum;
                    end else begin
                        next_s.ptr0 = psum;
                    end
                end else if (s.cmd.op != op_none) begin
                    next_s.res = res;
                    next_s.z   = res == 8'h00;                          // [RQ12]
                    if (lit_op || !s.cmd.dest) begin                    // [RQ6]
                        next_s.acc = res;                               // [RQ3] [RQ4]
                    end else begin
                        next_s.rf[fidx] = res;                          // [RQ5]
                    end
                    if (s.cmd.op == arith_shift_right) begin
                        next_s.c = fval[0];                             // [RQ8]
                    end else if (s.cmd.op != and_literal_accumulator &&
                                 s.cmd.op != and_accumulator_register) begin
                        next_s.c  = sum9[8];                            // [RQ4] [RQ7] [RQ10]
                        next_s.dc = nib5[4];
                    end
                end
            end
            default: begin
                next_s.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s       <= '0;
            s.state <= ST_IDLE;
            s.acc   <= ACC_RST;
            s.ptr0  <= PTR_RST;
            s.ptr1  <= PTR_RST;
            s.cmd   <= '{faddr: 7'h00, lit: 8'h00, ptr_sel: 1'b0, dest: 1'b0, op: op_none};
        end else begin
            s <= next_s;
        end
    end

    assign pready  = s.rdy;
    assign pslverr = s.rdy && s.err;
    assign prdata  = s.rdata;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ptr_add;
        exec && s.cmd.op == add_literal_to_pointer && !s.cmd.ptr_sel |=>
            s.ptr0 == $past(s.ptr0) + {{10{$past(s.cmd.lit[5])}}, $past(s.cmd.lit[5:0])} &&
            s.c == $past(s.c) && s.dc == $past(s.dc) && s.z == $past(s.z);
    endproperty
    a_ptr_add: assert property (p_ptr_add) else $error("pointer add wrong"); // [RQ1] [RQ2]

    property p_and_lit;
        exec && s.cmd.op == and_literal_accumulator |=>
            s.acc == ($past(s.acc) & $past(s.cmd.lit)) && s.c == $past(s.c) && s.dc == $past(s.dc);
    endproperty
    a_and_lit: assert property (p_and_lit) else $error("literal and wrong"); // [RQ3]

    property p_add_lit;
        exec && s.cmd.op == add_literal_accumulator |=>
            {s.c, s.acc} == {1'b0, $past(s.acc)} + {1'b0, $past(s.cmd.lit)};
    endproperty
    a_add_lit: assert property (p_add_lit) else $error("literal add wrong"); // [RQ4]

    property p_and_reg;
        exec && s.cmd.op == and_accumulator_register && !s.cmd.dest |=>
            s.acc == ($past(s.acc) & $past(fval)) && s.c == $past(s.c);
    endproperty
    a_and_reg: assert property (p_and_reg) else $error("register and wrong"); // [RQ5]

    property p_dest_reg;
        exec && bals_reg_op(s.cmd.op) && s.cmd.dest |=>
            s.acc == $past(s.acc) && s.rf[$past(fidx)] == s.res;
    endproperty
    a_dest_reg: assert property (p_dest_reg) else $error("destination wrong"); // [RQ6]

    property p_add_reg;
        exec && s.cmd.op == add_accumulator_register |=>
            s.dc == $past(nib5[4]) && s.res == $past(s.acc) + $past(fval);
    endproperty
    a_add_reg: assert property (p_add_reg) else $error("register add wrong"); // [RQ7]

    property p_shift;
        exec && s.cmd.op == arith_shift_right |=>
            s.c == $past(fval[0]) && s.res == {$past(fval[7]), $past(fval[7:1])} &&
            s.dc == $past(s.dc);
    endproperty
    a_shift: assert property (p_shift) else $error("shift wrong"); // [RQ8] [RQ9]

    property p_add_carry;
        exec && s.cmd.op == add_with_carry_register && !s.cmd.dest |=>
            {s.c, s.acc} == {1'b0, $past(s.acc)} + {1'b0, $past(fval)} + {8'h00, $past(s.c)};
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("carry add wrong"); // [RQ10]

    property p_extra;
        take && apb_req.pwrite && a == CMD_OFS && needs_extra |=>
            s.state == ST_EXTRA ##1 s.state == ST_EXEC ##1 s.state == ST_IDLE;
    endproperty
    a_extra: assert property (p_extra) else $error("extra cycle missing"); // [RQ11]

    property p_zero;
        exec && s.cmd.op != add_literal_to_pointer && s.cmd.op != op_none |=>
            s.z == (s.res == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong"); // [RQ12]

    property p_ptr_add1;
        exec && s.cmd.op == add_literal_to_pointer && s.cmd.ptr_sel |=>
            s.ptr1 == $past(s.ptr1) + {{10{$past(s.cmd.lit[5])}}, $past(s.cmd.lit[5:0])} &&
            s.ptr0 == $past(s.ptr0) && s.acc == $past(s.acc) && s.c == $past(s.c) && s.z == $past(s.z);
    endproperty
    a_ptr_add1: assert property (p_ptr_add1) else $error("second pointer add wrong"); // [RQ1] [RQ2]

    // literal ops ignore the destination bit and leave the file alone
    property p_lit_dest;
        exec && lit_op |=>
            s.acc == s.res && s.rf[$past(fidx)] == $past(fval);
    endproperty
    a_lit_dest: assert property (p_lit_dest) else $error("literal op reached the file"); // [RQ3] [RQ4]

    property p_and_reg_flags;
        exec && s.cmd.op == and_accumulator_register |=>
            s.res == ($past(s.acc) & $past(fval)) && s.c == $past(s.c) && s.dc == $past(s.dc);
    endproperty
    a_and_reg_flags: assert property (p_and_reg_flags) else $error("register and flags wrong"); // [RQ5]

    property p_dest_acc;
        exec && bals_reg_op(s.cmd.op) && !s.cmd.dest |=>
            s.acc == s.res && s.rf[$past(fidx)] == $past(fval);
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination wrong"); // [RQ6]

    property p_add_carry_res;
        exec && s.cmd.op == add_with_carry_register |=>
            s.res == $past(s.acc) + $past(fval) + {7'h00, $past(s.c)} && s.dc == $past(nib5[4]);
    endproperty
    a_add_carry_res: assert property (p_add_carry_res) else $error("carry add result wrong"); // [RQ10] [RQ12]

    property p_no_extra;
        take && apb_req.pwrite && a == CMD_OFS && !needs_extra |=>
            s.state == ST_EXEC ##1 s.state == ST_IDLE;
    endproperty
    a_no_extra: assert property (p_no_extra) else $error("needless extra cycle"); // [RQ11]

    // no access completes while an op is still running
    property p_busy_wait;
        s.state != ST_IDLE |-> !pready;
    endproperty
    a_busy_wait: assert property (p_busy_wait) else $error("ready while busy"); // [RQ11]

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

    property p_err_zero;
        pslverr |-> prdata == 32'h0000_0000;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");

endmodule

`default_nettype wire

// File: tb/bals_host.sv
/*
 apb master standing in for the core's decoder side.
 assumes pclk free running; pready answers within 1000 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module bals_host (
    // clock
    input  wire logic                       pclk,
    // apb
    output var  bals_pkg::bals_apb_req_type apb_req,
    input  wire logic [31:0]                prdata,
    input  wire logic                       pready,
    input  wire logic                       pslverr,
    // status
    output var  logic                       timed_out
);
    import bals_pkg::*;
    initial begin
        apb_req   = '0;
        timed_out = 1'b0;
    end
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= a;
        apb_req.pwdata  <= wd;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 1000);
        if (pready !== 1'b1) timed_out = 1'b1;
        rd  = prdata;
        err = pslverr;
        // released lines show the inverse so stale values are not mistaken
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
        apb_req.paddr   <= ~a;
        apb_req.pwdata  <= ~wd;
    endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/*
 self-checking bench of the byte alu with a reference model.
 assumes bals_host as the apb master and the map of bals_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bals_pkg::*;
    logic             pclk;
    logic             presetn;
    bals_apb_req_type apb_req;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             timed_out;
    logic             last_err;
    int               err_count;
    int               comparisons;
    int               cyc = 0;
    int               dt [2];
    logic [7:0]       acc;
    logic [7:0]       rf [128];
    logic [15:0]      ptr [2];
    logic             c;
    logic             nc;
    logic             z;
    logic [7:0]       last;
    logic [6:0]       ix;
    logic [31:0]      d;
    logic [31:0]      rnd;
    bals_cmd_type     cmd;

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    bals_alu dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
                  .pready(pready), .pslverr(pslverr));
    bals_host u_host (.pclk(pclk), .apb_req(apb_req), .prdata(prdata), .pready(pready),
                      .pslverr(pslverr), .timed_out(timed_out));

    task automatic complete_run();
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        u_host.xfer(wr, a, wd, d, last_err);
        if (timed_out === 1'b1) begin
            err_count++;
            complete_run();
        end
    endtask
    function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + 9'(ci);
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
        return {s[8], h[4], s[7:0]};
    endfunction
    // reference model of one command
    task automatic run(input bals_cmd_type k);
        logic [7:0] f;
        logic [7:0] r;
        ix = (k.faddr < 7'h02) ? ptr[k.faddr[0]][6:0] : k.faddr;
        f  = rf[ix];
        r  = 8'h00;
        case (k.op)
            add_literal_to_pointer:   ptr[k.ptr_sel] = ptr[k.ptr_sel] + {{10{k.lit[5]}}, k.lit[5:0]};
            and_literal_accumulator:  r = acc & k.lit;
            add_literal_accumulator:  {c, nc, r} = add8(acc, k.lit, 1'b0);
            and_accumulator_register: r = acc & f;
            add_accumulator_register: {c, nc, r} = add8(acc, f, 1'b0);
            arith_shift_right: begin
                r = {f[7], f[7:1]};
                c = f[0];
            end
            add_with_carry_register:  {c, nc, r} = add8(acc, f, c);
            default: ;
        endcase
        if (k.op != add_literal_to_pointer && k.op != op_none) begin
            z    = (r == 8'h00);
            last = r;
            if (k.op >= and_accumulator_register && k.dest) rf[ix] = r;
            else acc = r;
        end
    endtask
    task automatic exec_check(input bals_cmd_type k);
        bus(1'b1, CMD_OFS, {8'h00, 1'b0, k.faddr, k.lit, 3'h0, k.ptr_sel, k.dest, k.op});
        run(k);
        bus(1'b0, ACC_OFS, 32'h0);
        chk("acc", d, {24'h0, acc});
        bus(1'b0, FLAG_OFS, 32'h0);
        chk("flags", d, {29'h0, z, nc, c});
        bus(1'b0, PTR0_OFS, 32'h0);
        chk("ptr0", d, {16'h0, ptr[0]});
        bus(1'b0, PTR1_OFS, 32'h0);
        chk("ptr1", d, {16'h0, ptr[1]});
        bus(1'b0, {RF_PAGE, ix, 2'b00}, 32'h0);
        chk("file", d, {24'h0, rf[ix]});
        if (k.op != add_literal_to_pointer) begin
            bus(1'b0, STAT_OFS, 32'h0);
            chk("result", d, {16'h0, last, 8'h00});
        end
    endtask

    initial begin
        presetn     = 1'b0;
        err_count   = 0;
        comparisons = 0;
        rnd         = $urandom(13);
        {acc, c, nc, z, last} = '0;
        ptr = '{PTR_RST, PTR_RST};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        bus(1'b0, CMD_OFS, 32'h0);
        chk("cmd reset", d, 32'h7);
        bus(1'b0, ACC_OFS, 32'h0);
        chk("acc reset", d, {24'h0, ACC_RST});
        bus(1'b0, 12'h100, 32'h0);
        chk("unmapped", {d[31:1], last_err}, 32'h1);
        for (int i = 0; i < 128; i++) begin
            rf[i] = 8'($urandom);
            bus(1'b1, {RF_PAGE, 7'(i), 2'b00}, {24'h0, rf[i]});
        end
        for (int i = 0; i < 300; i++) begin
            {acc, z, nc, c} = 11'($urandom);
            bus(1'b1, ACC_OFS, {24'h0, acc});
            bus(1'b1, FLAG_OFS, {29'h0, z, nc, c});
            rnd = $urandom;
            case (i % 4)
                0: ptr[i % 2] = 16'hFFFF;
                1: ptr[i % 2] = 16'h0000;
                2: ptr[i % 2] = {1'b1, rnd[14:0]};
                default: ptr[i % 2] = rnd[31:16];
            endcase
            bus(1'b1, (i % 2) ? PTR1_OFS : PTR0_OFS, {16'h0, ptr[i % 2]});
            cmd    = rnd[$bits(bals_cmd_type)-1:0];
            cmd.op = bals_op_type'($urandom_range(0, 7));
            if (i < 16) begin
                cmd.op      = add_literal_to_pointer;
                cmd.ptr_sel = i[0];
                cmd.lit     = i[2] ? 8'h1F : 8'h20;
            end
            exec_check(cmd);
        end
        // same indirect op with the pointer's top bit clear, then set
        for (int k = 0; k < 2; k++) begin
            ptr[0] = {k[0], 15'h0005};
            bus(1'b1, PTR0_OFS, {16'h0, ptr[0]});
            cmd = '{faddr: IND0_ADDR, lit: 8'h00, ptr_sel: 1'b0, dest: 1'b1, op: add_accumulator_register};
            bus(1'b1, CMD_OFS, {8'h00, 1'b0, cmd.faddr, cmd.lit, 3'h0, cmd.ptr_sel, cmd.dest, cmd.op});
            dt[k] = cyc;
            bus(1'b0, ACC_OFS, 32'h0);
            dt[k] = cyc - dt[k];
            run(cmd);
        end
        chk("extra cycle", 32'(dt[1] - dt[0]), 32'h1);
        bus(1'b0, {RF_PAGE, 7'h05, 2'b00}, 32'h0);
        chk("indirect", d, {24'h0, rf[5]});
        complete_run();
    end
endmodule
`default_nettype wire
